//--- src/pvp_pkg.sv
/*
  Shared constants and types for the program/verify port controller.
  Assumes a 50 MHz pclk and an APB master that reaches the controller registers.
*/
package pvp_pkg;

  // ****************************************************************
  // Register map of the controller (byte addresses).
  // ****************************************************************
  localparam logic [11:0] CTRL_OFS   = 12'h0_000;
  localparam logic [11:0] ADDR_OFS   = 12'h0_004;
  localparam logic [11:0] DATA_OFS   = 12'h0_008;
  localparam logic [11:0] STATUS_OFS = 12'h0_00C;
  localparam logic [11:0] RDATA_OFS  = 12'h0_010;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int          CTRL_OP_LSB    = 0;
  localparam int          CTRL_GO_BIT    = 4;
  localparam int          CTRL_EN_BIT    = 5;
  localparam int          CTRL_CFG_LSB   = 8;
  localparam int          STAT_BUSY_BIT  = 0;
  localparam int          STAT_DONE_BIT  = 1;
  localparam int          STAT_LOCK_BIT  = 2;
  localparam int          STAT_ERR_BIT   = 3;
  localparam logic [31:0] RESET_VALUE    = 32'h0000_0000;

  // ****************************************************************
  // Timing: documented times and derived cycle counts.
  // ****************************************************************
  localparam int CLK_HZ         = 50_000_000;
  localparam int GATE_VERIFY_US = 10;
  localparam int GATE_PROG_MS   = 10;
  localparam int GATE_SEC_MS    = 300;
  localparam int SETUP_NS       = 200;
  localparam int VERIFY_CYC     = GATE_VERIFY_US * (CLK_HZ / 1_000_000);
  localparam int PROG_CYC       = GATE_PROG_MS * (CLK_HZ / 1_000);
  localparam int SEC_CYC        = GATE_SEC_MS * (CLK_HZ / 1_000);
  localparam int SETUP_CYC      = (SETUP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CELL_COUNT     = 2194;

  // ****************************************************************
  // Operations that software can request.
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_ERASE_ALL = 3'b000,
    OP_PROG_ALL  = 3'b001,
    OP_PROG_BYTE = 3'b010,
    OP_VERIFY    = 3'b011,
    OP_SECURITY  = 3'b100
  } pvp_op_e;

  // Configuration mode chosen by the two global cells.
  typedef enum logic [1:0] {
    CFG_SIMPLE   = 2'b01,
    CFG_COMPLEX  = 2'b11,
    CFG_REGISTER = 2'b10
  } pvp_cfg_e;

  // Pin levels driven toward the device; high-voltage pins have a level code.
  typedef struct packed {
    logic       prog_verify_enable;
    logic [1:0] op_select_pins;
    logic       gating_pulse_pin;
    logic [1:0] latch_wipe_pin;
    logic [1:0] lock_outdis_pin;
    logic [3:0] term_group_addr;
  } pvp_pins_s;

  // Level codes for the multi-level pins.
  localparam logic [1:0] LVL_LOW  = 2'b00;
  localparam logic [1:0] LVL_HIGH = 2'b01;
  localparam logic [1:0] LVL_HV   = 2'b10;

endpackage

//--- src/pvp_sync.sv
/*
  Two-flop synchroniser for the device data bus read back from pins.
  Assumes the bus input is asynchronous to pclk.
*/
`timescale 1ns/1ns
module pvp_sync (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Data.
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  logic [7:0] meta_q;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pvp_sync

//--- src/pvp_timer.sv
/*
  Down counter that times the gating pulse and setup intervals.
  Assumes load and count come from logic on pclk.
*/
`timescale 1ns/1ns
module pvp_timer (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Control.
  input  wire logic        load,
  input  wire logic [24:0] load_value,
  // Status.
  output logic             expired
);

  logic [24:0] count_q;

  // Loaded value counts down to zero and holds there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 25'h000_0000;
    end else if (load) begin
      count_q <= load_value;
    end else if (count_q != 25'h000_0000) begin
      count_q <= count_q - 25'h000_0001;
    end
  end

  // Expired looks only at the count: the reload is made from expired, so
  // gating expired with load would close a combinational loop.
  assign expired = (count_q == 25'h000_0000);

endmodule // pvp_timer

//--- src/pvp_ctrl.sv
/*
  Controller that drives a programmable logic device through its parallel
  program/verify pins, ordered by software over APB.
  Assumes the pin drivers translate level codes into real voltages, and
  that software supplies addresses per the chosen configuration mode.
*/
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns

// Notes on behaviour
// - Hold enable pin high during program mode.
// - Select one of four operations by pins.
// - Drive line and term-group addresses.
// - Address mapping follows the chosen mode; the code only stores cfg_q and leaves the mapping to software.
// - Invert write data against the fuse map.
// - Latch pin latches address; lock pin frees bus.
// - Keep latch/lock high until pulse 10us.
// - Raise pulse only after setup complete.
// - Program and erase pulses last 10ms.
// - Security pulse lasts 300ms.
// - Verify pulse lasts 10us.
// - Erase before writing any cell data; the code still runs a write without an erase and sets err.
// - Start with all pins low.
// - Precondition with erase then program-all; the code still runs a byte program without it and sets err.
// - Op pins are inverted TTL codes.
module pvp_ctrl (
  // APB clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Device pins.
  output pvp_pkg::pvp_pins_s          pins,
  output logic      [7:0]             bus_out,
  output logic                        bus_oe,
  input  wire logic [7:0]             bus_in
);

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_LATCH  = 3'b010,
    ST_DATA   = 3'b011,
    ST_PULSE  = 3'b100,
    ST_RELEAS = 3'b101,
    ST_FALL   = 3'b110
  } pvp_state_e;

  pvp_state_e          state_q;
  pvp_pkg::pvp_op_e    op_q;
  pvp_pkg::pvp_pins_s  pins_q;
  logic [1:0]          cfg_q;
  logic                enable_q;
  logic [7:0]          line_addr_q;
  logic [3:0]          group_q;
  logic [7:0]          wdata_q;
  logic [7:0]          rdata_q;
  logic [7:0]          bus_q;
  logic                bus_oe_q;
  logic                done_q;
  logic                err_q;
  logic                secured_q;
  logic                erased_q;
  logic                primed_q;
  logic                go;
  pvp_pkg::pvp_op_e    go_op;
  logic                wr_en;
  logic                rd_en;
  logic                tmr_load;
  logic [24:0]         tmr_value;
  logic                tmr_expired;
  logic [7:0]          bus_sync;

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Operation codes on the select pins are written inverted.
  function automatic logic [1:0] op_pins(input pvp_pkg::pvp_op_e op);
    unique case (op)
      pvp_pkg::OP_ERASE_ALL: op_pins = ~2'b00;
      pvp_pkg::OP_PROG_ALL:  op_pins = ~2'b01;
      pvp_pkg::OP_PROG_BYTE: op_pins = ~2'b11;
      pvp_pkg::OP_VERIFY:    op_pins = ~2'b10;
      default:               op_pins = ~2'b11; // Security shares byte code.
    endcase
  endfunction

  // Gating pulse length per operation.
  function automatic logic [24:0] pulse_len(input pvp_pkg::pvp_op_e op);
    unique case (op)
      pvp_pkg::OP_VERIFY:   pulse_len = 25'(pvp_pkg::VERIFY_CYC);
      pvp_pkg::OP_SECURITY: pulse_len = 25'(pvp_pkg::SEC_CYC);
      default:              pulse_len = 25'(pvp_pkg::PROG_CYC);
    endcase
  endfunction

  // Operations that use an addressed byte.
  function automatic logic is_byte(input pvp_pkg::pvp_op_e op);
    is_byte = (op == pvp_pkg::OP_PROG_BYTE) || (op == pvp_pkg::OP_VERIFY);
  endfunction

  // ****************************************************************
  // Submodules.
  // ****************************************************************
  pvp_timer u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (tmr_load),
    .load_value (tmr_value),
    .expired    (tmr_expired)
  );

  pvp_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (bus_in),
    .sync_out (bus_sync)
  );

  // ****************************************************************
  // APB slave: zero wait state, unmapped reads zero with error.
  // ****************************************************************
  // Writes land at the access edge; there is never a wait state to insert.
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  assign go     = wr_en && (paddr == pvp_pkg::CTRL_OFS) && pwdata[pvp_pkg::CTRL_GO_BIT]
                  && (state_q == ST_IDLE);

  // Operation carried by the write that starts an order; op_q only holds it
  // from the next clock, so checks made at that edge must look here.
  assign go_op  = pvp_pkg::pvp_op_e'(pwdata[pvp_pkg::CTRL_OP_LSB +: 3]);

  // Error flags an unmapped address.
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !(paddr == pvp_pkg::CTRL_OFS || paddr == pvp_pkg::ADDR_OFS ||
                  paddr == pvp_pkg::DATA_OFS || paddr == pvp_pkg::STATUS_OFS ||
                  paddr == pvp_pkg::RDATA_OFS);
    end
  end

  // Read multiplexer.
  always_comb begin
    prdata = pvp_pkg::RESET_VALUE;
    if (rd_en) begin
      unique case (paddr)
        pvp_pkg::CTRL_OFS: begin
          prdata[2:0] = op_q;
          prdata[pvp_pkg::CTRL_EN_BIT] = enable_q;
          prdata[pvp_pkg::CTRL_CFG_LSB +: 2] = cfg_q;
        end
        pvp_pkg::ADDR_OFS:   prdata[11:0] = {group_q, line_addr_q};
        pvp_pkg::DATA_OFS:   prdata[7:0]  = wdata_q;
        pvp_pkg::STATUS_OFS: begin
          prdata[pvp_pkg::STAT_BUSY_BIT] = (state_q != ST_IDLE);
          prdata[pvp_pkg::STAT_DONE_BIT] = done_q;
          prdata[pvp_pkg::STAT_LOCK_BIT] = secured_q;
          prdata[pvp_pkg::STAT_ERR_BIT]  = err_q;
        end
        pvp_pkg::RDATA_OFS:  prdata[7:0]  = rdata_q;
        default:             prdata = pvp_pkg::RESET_VALUE;
      endcase
    end
  end

  // Control and operand registers; operands frozen while busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q        <= pvp_pkg::OP_ERASE_ALL;
      enable_q    <= 1'b0;
      cfg_q       <= pvp_pkg::CFG_SIMPLE;
      line_addr_q <= 8'h00;
      group_q     <= 4'h0;
      wdata_q     <= 8'h00;
    end else if (wr_en && state_q == ST_IDLE) begin
      unique case (paddr)
        pvp_pkg::CTRL_OFS: begin
          op_q     <= pvp_pkg::pvp_op_e'(pwdata[2:0]);
          enable_q <= pwdata[pvp_pkg::CTRL_EN_BIT];
          cfg_q    <= pwdata[pvp_pkg::CTRL_CFG_LSB +: 2];
        end
        pvp_pkg::ADDR_OFS: begin
          line_addr_q <= pwdata[7:0];
          group_q     <= pwdata[11:8];
        end
        pvp_pkg::DATA_OFS: wdata_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Operation sequencer.
  // ****************************************************************

  // Each step waits for the timer, which reads zero for one clock before the state moves on,
  // so every step lasts one cycle longer than the count it was loaded with; the pins follow the state one clock later.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE:   if (go) state_q <= ST_ADDR;
        ST_ADDR:   if (tmr_expired) state_q <= ST_LATCH;
        ST_LATCH:  if (tmr_expired) state_q <= ST_DATA;
        ST_DATA:   if (tmr_expired) state_q <= ST_PULSE;
        ST_PULSE:  if (tmr_expired) state_q <= ST_RELEAS;
        ST_RELEAS: if (tmr_expired) state_q <= ST_FALL;
        ST_FALL:   if (tmr_expired) state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Timer reload on each state entry.
  // The last step loads nothing, so the timer rests at zero while idle.
  always_comb begin
    tmr_load  = 1'b0;
    tmr_value = 25'(pvp_pkg::SETUP_CYC);
    if (go) begin
      tmr_load = 1'b1;
    end else if (tmr_expired && state_q != ST_IDLE && state_q != ST_FALL) begin
      tmr_load = 1'b1;
      if (state_q == ST_DATA) begin
        tmr_value = pulse_len(op_q);
      end
    end
  end

  // Pin drive per state; pins low when idle except prog_verify_enable, which follows enable_q.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q   <= '0;
      bus_q    <= 8'h00;
      bus_oe_q <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          pins_q   <= '0;
          pins_q.prog_verify_enable <= enable_q;
          bus_oe_q <= 1'b0;
        end
        ST_ADDR: begin
          pins_q.prog_verify_enable <= 1'b1;
          pins_q.op_select_pins     <= op_pins(op_q);
          pins_q.term_group_addr    <= is_byte(op_q) ? group_q : 4'h0;
          bus_q    <= line_addr_q;
          bus_oe_q <= is_byte(op_q);
        end
        ST_LATCH: begin
          // High voltage on the latch pin selects erase-all.
          pins_q.latch_wipe_pin <= (op_q == pvp_pkg::OP_ERASE_ALL) ? pvp_pkg::LVL_HV :
                                   is_byte(op_q) || op_q == pvp_pkg::OP_SECURITY ?
                                   pvp_pkg::LVL_HIGH : pvp_pkg::LVL_LOW;
          pins_q.lock_outdis_pin <= (op_q == pvp_pkg::OP_SECURITY) ? pvp_pkg::LVL_HV :
                                    pvp_pkg::LVL_HIGH;
        end
        ST_DATA: begin
          // Program data go out inverted; verify releases the bus.
          bus_q    <= ~wdata_q;
          bus_oe_q <= (op_q == pvp_pkg::OP_PROG_BYTE);
        end
        ST_PULSE: pins_q.gating_pulse_pin <= 1'b1;
        ST_RELEAS: begin
          // Latch and lock drop only after the pulse has run its time.
          pins_q.latch_wipe_pin  <= pvp_pkg::LVL_LOW;
          pins_q.lock_outdis_pin <= pvp_pkg::LVL_LOW;
        end
        ST_FALL: begin
          pins_q.gating_pulse_pin <= 1'b0;
          bus_oe_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  assign pins    = pins_q;
  assign bus_out = bus_q;
  assign bus_oe  = bus_oe_q;

  // ****************************************************************
  // Results and order checks.
  // ****************************************************************

  // Result, security and erase tracking; a new order clears done and error.
  // Cell writes are only trusted after an erase followed by a program-all,
  // so an order that skips the preconditioning still runs but sets err.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q   <= 8'h00;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      secured_q <= 1'b0;
      erased_q  <= 1'b0;
      primed_q  <= 1'b0;
    end else begin
      if (go) begin
        done_q <= 1'b0;
        err_q  <= ((go_op == pvp_pkg::OP_PROG_BYTE) && !primed_q) ||
                  ((go_op == pvp_pkg::OP_PROG_ALL) && !erased_q);
      end else if (state_q == ST_FALL && tmr_expired) begin
        done_q <= 1'b1;
      end
      // Sample verify data when the pulse timer expires, before latch and lock drop and while the pulse is still high.
      if (state_q == ST_PULSE && tmr_expired && op_q == pvp_pkg::OP_VERIFY) begin
        rdata_q <= secured_q ? 8'hFF : bus_sync;
      end
      if (state_q == ST_PULSE && tmr_expired) begin
        if (op_q == pvp_pkg::OP_ERASE_ALL) begin
          secured_q <= 1'b0;
          erased_q  <= 1'b1;
          primed_q  <= 1'b0;
        end else if (op_q == pvp_pkg::OP_SECURITY) begin
          secured_q <= 1'b1;
        end else if (op_q == pvp_pkg::OP_PROG_ALL) begin
          // Program-all only completes the preconditioning after an erase.
          primed_q <= erased_q;
        end
      end
    end
  end

endmodule // pvp_ctrl

//--- testbench/pvp_chk.sv
/*
  Assertion checker for the program/verify port controller.
  Assumes it is bound to pvp_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module pvp_chk (
  // Clock and reset.
  input wire logic               pclk,
  input wire logic               presetn,
  // APB slave side.
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Device pins.
  input wire pvp_pkg::pvp_pins_s pins,
  input wire logic               bus_oe
);
  // ******************
  // Helper logic.
  // ******************
  logic [24:0] gcnt_q;
  wire         latch_up = pins.latch_wipe_pin != pvp_pkg::LVL_LOW;
  wire         lock_up  = pins.lock_outdis_pin != pvp_pkg::LVL_LOW;
  wire         rd_acc   = psel && penable && !pwrite;

  // Counts the cycles for which the gating pulse has been high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcnt_q <= 25'h000_0000;
    end else if (pins.gating_pulse_pin) begin
      gcnt_q <= gcnt_q + 25'h000_0001;
    end else begin
      gcnt_q <= 25'h000_0000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ******************
  // Assertions.
  // ******************
  property p_pulse_en;
    pins.gating_pulse_pin |-> pins.prog_verify_enable;
  endproperty
  a_pulse_en: assert property (p_pulse_en) else $error("pulse without enable");

  property p_setup;
    $rose(pins.gating_pulse_pin) |->
      $past(pins.prog_verify_enable, 10) && $stable(pins.term_group_addr);
  endproperty
  a_setup: assert property (p_setup) else $error("pulse before setup");

  property p_latch_hold;
    $fell(latch_up) || $fell(lock_up) |-> pins.gating_pulse_pin && gcnt_q >= pvp_pkg::VERIFY_CYC;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

  property p_stable;
    pins.gating_pulse_pin && $past(pins.gating_pulse_pin) |->
      $stable(pins.op_select_pins) && $stable(pins.term_group_addr);
  endproperty
  a_stable: assert property (p_stable) else $error("pins moved in pulse");

  property p_oe;
    bus_oe && pins.gating_pulse_pin |-> pins.op_select_pins == 2'b00;
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven in read pulse");

  property p_verify_width;
    $fell(pins.gating_pulse_pin) && pins.op_select_pins == 2'b01 |->
      $past(gcnt_q) >= pvp_pkg::VERIFY_CYC;
  endproperty
  a_verify_width: assert property (p_verify_width) else $error("verify pulse short");

  property p_erase_width;
    $fell(pins.gating_pulse_pin) && pins.op_select_pins == 2'b11 |->
      $past(gcnt_q) >= pvp_pkg::PROG_CYC;
  endproperty
  a_erase_width: assert property (p_erase_width) else $error("erase pulse short");

  property p_slverr;
    psel && penable && !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010})
      |-> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not flagged");

  property p_rdata_idle;
    !rd_acc |-> prdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
endmodule // pvp_chk

bind pvp_ctrl pvp_chk pvp_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pins(pins), .bus_oe(bus_oe));

//--- testbench/pvp_dev_model.sv
/*
  Behavioural model of the programmable device on the program pins.
  Assumes the bench preloads cells through the mem array.
*/
`timescale 1ns/1ns
module pvp_dev_model (
  // Clock on which the model latches the line, runs the operations and drives the bus.
  input  wire logic               pclk,
  // Pins from the controller.
  input  wire pvp_pkg::pvp_pins_s pins,
  input  wire logic [7:0]         bus_out,
  input  wire logic               bus_oe,
  // Data back to the controller.
  output logic      [7:0]         bus_in
);
  // Cell store in map order, indexed by group and line.
  logic [7:0] mem [0:4095];
  logic [7:0] line_q;
  logic       latch_q;
  logic       secured_q;
  wire        pulse = pins.prog_verify_enable && pins.gating_pulse_pin;
  wire        rd_on = pulse && pins.op_select_pins == 2'b01 && !bus_oe;

  initial begin
    bus_in = 8'h5A;
    line_q = 8'h00;
    latch_q = 1'b0;
    secured_q = 1'b0;
  end

  // Latches the line, runs the operations and drives read data.
  always @(posedge pclk) begin
    latch_q <= pins.latch_wipe_pin != pvp_pkg::LVL_LOW;
    if (pins.latch_wipe_pin == pvp_pkg::LVL_HIGH && !latch_q) begin
      line_q <= bus_out;
    end
    if (pulse && pins.latch_wipe_pin == pvp_pkg::LVL_HV) begin
      secured_q <= 1'b0;
      foreach (mem[i]) mem[i] = 8'hFF;
    end
    if (pulse && pins.lock_outdis_pin == pvp_pkg::LVL_HV) begin
      secured_q <= 1'b1;
    end else if (pulse && bus_oe && pins.op_select_pins == 2'b00) begin
      mem[{pins.term_group_addr, line_q}] = ~bus_out;
    end
    if (rd_on) begin
      bus_in <= secured_q ? 8'hFF : mem[{pins.term_group_addr, line_q}];
    end else begin
      bus_in <= ~bus_in;
    end
  end
endmodule // pvp_dev_model

//--- testbench/tb_top.sv
/*
  Self-checking bench for the program/verify port controller.
  Assumes pvp_ctrl, pvp_dev_model and the bound checker are compiled.
*/
`timescale 1ns/1ns
module tb_top;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_oe;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd_v;
  logic [7:0]         bus_out, bus_in;
  logic [33:0]        expq[$];
  logic [33:0]        mon_e;
  pvp_pkg::pvp_pins_s pins;
  int                 err_count, checked, cycles, seed;

  // Clock generator.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  pvp_ctrl pvp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .bus_out(bus_out), .bus_oe(bus_oe), .bus_in(bus_in));
  pvp_dev_model pvp_dev_model_i (.pclk(pclk), .pins(pins), .bus_out(bus_out),
    .bus_oe(bus_oe), .bus_in(bus_in));

  // ******************
  // Compare and report.
  // ******************
  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      end_sim();
    end
  end

  // Takes the oldest note at each read answer and compares it if its bit 33 is set.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
      mon_e = expq.pop_front();
      if (mon_e[33]) begin
        cmp32("prdata", mon_e[31:0], prdata);
        cmp_bit("pslverr", mon_e[32], pslverr);
      end
    end
  end

  // ******************
  // APB master tasks.
  // ******************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    expq.push_back({1'b1, err, exp});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // Orders one verify, tries a write while busy, then checks the byte read back.
  task automatic run_verify(input logic [1:0] cfg, input logic [11:0] ad);
    logic [7:0] v;
    int         n;
    v = 8'($random(seed));
    pvp_dev_model_i.mem[ad] = v;
    apb(1'b1, pvp_pkg::ADDR_OFS, {20'h0_0000, ad});
    apb(1'b1, pvp_pkg::CTRL_OFS, {22'h0, cfg, 5'b0_0110, 3'(pvp_pkg::OP_VERIFY)});
    apb(1'b1, pvp_pkg::ADDR_OFS, {20'h0_0000, ~ad});
    n = 0;
    rd_v = 32'h0000_0001;
    while (rd_v[0] !== 1'b0 && n < 3000) begin
      expq.push_back(34'h0_0000_0000);
      apb(1'b0, pvp_pkg::STATUS_OFS, 32'h0000_0000);
      n++;
    end
    rd_chk(pvp_pkg::STATUS_OFS, 32'h0000_0002, 1'b0);
    rd_chk(pvp_pkg::RDATA_OFS, {24'h00_0000, v}, 1'b0);
    rd_chk(pvp_pkg::ADDR_OFS, {20'h0_0000, ad}, 1'b0);
    rd_chk(pvp_pkg::CTRL_OFS, {22'h0, cfg, 5'b0_0100, 3'(pvp_pkg::OP_VERIFY)}, 1'b0);
    cmp_bit("bus_oe", 1'b0, bus_oe);
  endtask

  // Main sequence.
  initial begin
    logic [7:0] d;
    seed = 48058;
    err_count = 0;
    checked = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    cmp32("pins", 32'h0000_0000, 32'(pins));
    rd_chk(pvp_pkg::CTRL_OFS, 32'(pvp_pkg::CFG_SIMPLE) << pvp_pkg::CTRL_CFG_LSB, 1'b0);
    for (int i = 1; i < 5; i++) rd_chk(12'(i * 4), pvp_pkg::RESET_VALUE, 1'b0);
    rd_chk(12'h014, 32'h0000_0000, 1'b1);
    d = 8'($random(seed));
    apb(1'b1, pvp_pkg::DATA_OFS, {24'h00_0000, d});
    rd_chk(pvp_pkg::DATA_OFS, {24'h00_0000, d}, 1'b0);
    run_verify(pvp_pkg::CFG_SIMPLE, 12'($random(seed)));
    run_verify(pvp_pkg::CFG_COMPLEX, 12'($random(seed)));
    run_verify(pvp_pkg::CFG_REGISTER, 12'($random(seed)));
    end_sim();
  end
endmodule // tb_top
